// File: hw/bcg_clock_gen.v
// Boot mode selection and clock generation control
`timescale 1ns/1ps
`include "bcg_defs.vh"

module bcg_clock_gen (
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_rst_n,
  // Boot straps and flash state
  input  wire       i_boot_select_pin,
  input  wire       i_tms,
  input  wire       i_port0_bit0,
  input  wire       i_flash_protected,
  // Software control bits
  input  wire       i_ext_osc_select,
  input  wire       i_osc_disconnect,
  input  wire       i_vco_bypass,
  input  wire [5:0] i_feedback_divider,
  input  wire       i_toggle_latch_enable,
  input  wire [1:0] i_clock_output_pin_select,
  input  wire       i_clock_output_pin_enable,
  input  wire       i_idle,
  input  wire       i_slowdown,
  input  wire [3:0] i_slowdown_factor,
  input  wire       i_power_down,
  // Analog status
  input  wire       i_osc_clk,
  input  wire       i_pll_locked,
  // Boot results
  output reg  [1:0] o_boot_mode,
  output reg        o_boot_valid,
  output reg        o_debug_refused,
  output reg        o_jtag_active,
  output reg [15:0] o_pc_start,
  // Clock unit control toward analog
  output reg        o_ext_osc_en,
  output reg        o_osc_power_en,
  output reg        o_pll_power_en,
  output reg  [1:0] o_clock_mode,
  output reg  [5:0] o_n_factor,
  output reg  [7:0] o_p_factor,
  output reg  [7:0] o_k_factor,
  // Fail-safe status
  output reg        o_osc_fail,
  output reg        o_lock_lost,
  // Derived clock strobes
  output reg        o_cpu_clk_en,
  output reg        o_periph_clk_en,
  output reg        o_ccu_clk_en,
  output reg        o_flash_fast_en,
  output reg        o_flash_slow_en,
  // Shared clock output pin
  output reg        o_clock_output_pin,
  output reg        o_clock_output_oe
);

  //--------------------------------------------------------------------
  // Strap, oscillator and lock synchronisers
  //--------------------------------------------------------------------
  reg [2:0] sel_sync_reg;
  reg [2:0] tms_sync_reg;
  reg [2:0] p00_sync_reg;
  reg [2:0] osc_sync_reg;
  reg [2:0] lock_sync_reg;
  reg       sel_reg;
  reg       tms_reg;
  reg       p00_reg;
  reg       lock_reg;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      sel_sync_reg  <= 3'h0;
      tms_sync_reg  <= 3'h0;
      p00_sync_reg  <= 3'h0;
      osc_sync_reg  <= 3'h0;
      lock_sync_reg <= 3'h7;
    end else begin
      sel_sync_reg  <= {sel_sync_reg[1:0], i_boot_select_pin};
      tms_sync_reg  <= {tms_sync_reg[1:0], i_tms};
      p00_sync_reg  <= {p00_sync_reg[1:0], i_port0_bit0};
      osc_sync_reg  <= {osc_sync_reg[1:0], i_osc_clk};
      lock_sync_reg <= {lock_sync_reg[1:0], i_pll_locked};
    end
  end

  // Accept a change once second and third stages agree
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      sel_reg  <= 1'b0;
      tms_reg  <= 1'b0;
      p00_reg  <= 1'b0;
      lock_reg <= 1'b1;
    end else begin
      if (sel_sync_reg[1] == sel_sync_reg[2])
        sel_reg <= sel_sync_reg[2];
      if (tms_sync_reg[1] == tms_sync_reg[2])
        tms_reg <= tms_sync_reg[2];
      if (p00_sync_reg[1] == p00_sync_reg[2])
        p00_reg <= p00_sync_reg[2];
      if (lock_sync_reg[1] == lock_sync_reg[2])
        lock_reg <= lock_sync_reg[2];
    end
  end

  //--------------------------------------------------------------------
  // Boot latch
  //--------------------------------------------------------------------
  // Straps settle through the filter before the latch closes
  reg [2:0] settle_reg;
  reg [1:0] boot_next;
  reg       refuse_next;

  always @* begin
    refuse_next = 1'b0;
    case ({sel_reg, tms_reg})
      2'b10: boot_next = `BCG_BOOT_USER;
      2'b00: boot_next = `BCG_BOOT_LOADER;
      2'b01: begin
        if (i_flash_protected) begin
          boot_next   = `BCG_BOOT_USER;
          refuse_next = 1'b1;
        end else begin
          boot_next = `BCG_BOOT_DEBUG;
        end
      end
      2'b11: boot_next = `BCG_BOOT_JTAG_USER;
      default: boot_next = `BCG_BOOT_USER;
    endcase
    // TMS high with bit0 high is not a listed option
    if (tms_reg && p00_reg) begin
      boot_next   = `BCG_BOOT_USER;
      refuse_next = 1'b0;
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      settle_reg      <= 3'h0;
      o_boot_valid    <= 1'b0;
      o_boot_mode     <= `BCG_BOOT_USER;
      o_debug_refused <= 1'b0;
      o_jtag_active   <= 1'b0;
      o_pc_start      <= `BCG_PC_START;
    end else if (!o_boot_valid) begin
      if (settle_reg == 3'h7) begin
        o_boot_valid    <= 1'b1;
        o_boot_mode     <= boot_next;
        o_debug_refused <= refuse_next;
        o_jtag_active   <= (boot_next == `BCG_BOOT_JTAG_USER) ||
                           (boot_next == `BCG_BOOT_DEBUG);
        o_pc_start      <= `BCG_PC_START;
      end else begin
        settle_reg <= settle_reg + 3'h1;
      end
    end
  end

  //--------------------------------------------------------------------
  // Oscillator source and mode
  //--------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ext_osc_en   <= 1'b0;
      o_osc_power_en <= 1'b1;
      o_pll_power_en <= 1'b1;
      o_clock_mode   <= `BCG_MODE_PLL;
      o_n_factor     <= `BCG_FEEDBACK_DIVIDER_RESET;
      o_p_factor     <= `BCG_P_FACTOR;
      o_k_factor     <= `BCG_K_FACTOR;
    end else begin
      o_ext_osc_en   <= i_ext_osc_select;
      o_osc_power_en <= !i_power_down;
      o_pll_power_en <= !i_power_down;
      if (i_osc_disconnect)
        o_clock_mode <= `BCG_MODE_BASE;
      else if (i_vco_bypass)
        o_clock_mode <= `BCG_MODE_PRESCALE;
      else
        o_clock_mode <= `BCG_MODE_PLL;
      o_n_factor <= i_feedback_divider;
      o_p_factor <= `BCG_P_FACTOR;
      o_k_factor <= `BCG_K_FACTOR;
    end
  end

  //--------------------------------------------------------------------
  // Fail-safe monitor
  //--------------------------------------------------------------------
  reg [7:0] osc_cnt_reg;
  wire      osc_edge = osc_sync_reg[1] ^ osc_sync_reg[2];

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      osc_cnt_reg <= 8'h00;
      o_osc_fail  <= 1'b0;
      o_lock_lost <= 1'b0;
    end else begin
      if (osc_edge || i_power_down) begin
        osc_cnt_reg <= 8'h00;
        o_osc_fail  <= 1'b0;
      end else if (osc_cnt_reg >= `BCG_OSC_TIMEOUT_CYC) begin
        o_osc_fail <= 1'b1;
      end else begin
        osc_cnt_reg <= osc_cnt_reg + 8'h01;
      end
      // Lock only matters while the VCO is in the path
      o_lock_lost <= !i_power_down && !lock_reg &&
                     (o_clock_mode == `BCG_MODE_PLL);
    end
  end

  //--------------------------------------------------------------------
  // Derived clock strobes
  //--------------------------------------------------------------------
  reg  [1:0] flash_cnt_reg;
  reg  [7:0] slow_div;
  wire       slow_tick;

  // Slow-down factor as a power of two, one when off
  always @* begin
    if (i_slowdown && i_slowdown_factor != 4'h0)
      slow_div = 8'h01 << (i_slowdown_factor[2:0]);
    else
      slow_div = 8'h01;
  end

  bcg_divider u_slow (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_run   (o_boot_valid && !i_power_down),
    .i_div   (slow_div),
    .o_tick  (slow_tick)
  );

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      flash_cnt_reg   <= 2'h0;
      o_cpu_clk_en    <= 1'b0;
      o_periph_clk_en <= 1'b0;
      o_ccu_clk_en    <= 1'b0;
      o_flash_fast_en <= 1'b0;
      o_flash_slow_en <= 1'b0;
    end else begin
      if (flash_cnt_reg == `BCG_FLASH_RATIO)
        flash_cnt_reg <= 2'h0;
      else
        flash_cnt_reg <= flash_cnt_reg + 2'h1;
      o_flash_fast_en <= o_boot_valid && !i_power_down;
      o_flash_slow_en <= o_boot_valid && !i_power_down &&
                         flash_cnt_reg == 2'h0;
      o_cpu_clk_en    <= slow_tick && !i_idle &&
                         flash_cnt_reg == 2'h0;
      o_periph_clk_en <= slow_tick && flash_cnt_reg == 2'h0;
      o_ccu_clk_en    <= slow_tick && flash_cnt_reg == 2'h0;
    end
  end

  //--------------------------------------------------------------------
  // Clock output on shared pin
  //--------------------------------------------------------------------
  reg toggle_reg;
  reg sel_clk;

  always @* begin
    case (i_clock_output_pin_select)
      2'h0: sel_clk = o_cpu_clk_en;
      2'h1: sel_clk = o_periph_clk_en;
      2'h2: sel_clk = o_flash_slow_en;
      default: sel_clk = o_flash_fast_en;
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      toggle_reg         <= 1'b0;
      o_clock_output_pin <= 1'b0;
      o_clock_output_oe  <= 1'b0;
    end else begin
      if (sel_clk)
        toggle_reg <= !toggle_reg;
      o_clock_output_oe <= i_clock_output_pin_enable && o_boot_valid;
      if (i_toggle_latch_enable)
        o_clock_output_pin <= toggle_reg;
      else
        o_clock_output_pin <= sel_clk;
    end
  end

endmodule // bcg_clock_gen

// File: hw/bcg_defs.vh
// Constants for the boot select and clock generation block
`ifndef BCG_DEFS_VH
`define BCG_DEFS_VH

// Boot modes
`define BCG_BOOT_USER       2'h0
`define BCG_BOOT_LOADER     2'h1
`define BCG_BOOT_DEBUG      2'h2
`define BCG_BOOT_JTAG_USER  2'h3
`define BCG_PC_START        16'h0000

// Clock modes
`define BCG_MODE_PLL        2'h0
`define BCG_MODE_PRESCALE   2'h1
`define BCG_MODE_BASE       2'h2

// Fixed dividers and feedback divider reset value
`define BCG_P_FACTOR        8'h01
`define BCG_K_FACTOR        8'h02
`define BCG_FEEDBACK_DIVIDER_RESET      6'h10

// Clock monitor: oscillator edges expected within this many cycles
`define BCG_OSC_TIMEOUT_NS  400
`define BCG_CLK_PERIOD_NS   4
`define BCG_OSC_TIMEOUT_CYC 8'h64

// Flash slow clock divides the fast one by three
`define BCG_FLASH_RATIO     2'h2

`endif

// File: hw/bcg_divider.v
// Programmable enable divider used for the derived clock strobes
`timescale 1ns/1ps

module bcg_divider (
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_rst_n,
  // Control
  input  wire       i_run,
  input  wire [7:0] i_div,
  // Strobe out
  output reg        o_tick
);

  reg [7:0] cnt_reg;

  // Divide by i_div, zero and one both pass every cycle
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= 8'h00;
      o_tick  <= 1'b0;
    end else if (!i_run) begin
      cnt_reg <= 8'h00;
      o_tick  <= 1'b0;
    end else if (cnt_reg + 8'h01 >= i_div) begin
      cnt_reg <= 8'h00;
      o_tick  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      o_tick  <= 1'b0;
    end
  end

endmodule // bcg_divider

// File: verification/bcg_clock_gen_assertions.sv
// Checker for the boot and clock generation block
`timescale 1ns/1ps
`include "bcg_defs.vh"
module bcg_clock_gen_assertions (
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_osc_disconnect,
  input wire logic       i_vco_bypass,
  input wire logic [5:0] i_feedback_divider,
  input wire logic       i_power_down,
  input wire logic       i_idle,
  input wire logic       o_boot_valid,
  input wire logic [1:0] o_boot_mode,
  input wire logic       o_debug_refused,
  input wire logic       o_osc_power_en,
  input wire logic       o_pll_power_en,
  input wire logic [1:0] o_clock_mode,
  input wire logic [5:0] o_n_factor,
  input wire logic [7:0] o_p_factor,
  input wire logic [7:0] o_k_factor,
  input wire logic       o_cpu_clk_en,
  input wire logic       o_clock_output_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_idle_held;
    i_idle [*3];
  endsequence
  AST_PK_FIXED: assert property (
    o_p_factor == 8'h01 && o_k_factor == 8'h02)
    else $error("fixed divider wrong");
  AST_N_FOLLOW: assert property (
    i_rst_n |=> o_n_factor == $past(i_feedback_divider))
    else $error("feedback factor not taken");
  AST_MODE_BASE: assert property (
    i_osc_disconnect |=> o_clock_mode == 2'h2)
    else $error("base mode not forced");
  AST_MODE_PLL: assert property (
    !i_osc_disconnect && !i_vco_bypass |=> o_clock_mode == 2'h0)
    else $error("pll mode not chosen");
  AST_MODE_PRE: assert property (
    !i_osc_disconnect && i_vco_bypass |=> o_clock_mode == 2'h1)
    else $error("prescaler mode not chosen");
  AST_POWER_OFF: assert property (
    i_power_down |=> !o_osc_power_en && !o_pll_power_en)
    else $error("power down left osc or pll on");
  AST_IDLE_STOP: assert property (
    s_idle_held |-> !o_cpu_clk_en)
    else $error("cpu strobe while idle");
  AST_BOOT_HOLD: assert property (
    o_boot_valid |=> o_boot_valid && $stable(o_boot_mode))
    else $error("boot result changed");
  AST_DEBUG_REF: assert property (
    o_debug_refused |-> o_boot_mode == 2'h0)
    else $error("refused debug not user mode");
  AST_STRAP_FIRST: assert property (
    !o_boot_valid |-> !o_clock_output_oe)
    else $error("clock out driven before strap latched");
endmodule // bcg_clock_gen_assertions
bind bcg_clock_gen bcg_clock_gen_assertions bcg_clock_gen_assertions_i (
  .i_clk, .i_rst_n, .i_osc_disconnect, .i_vco_bypass, .i_feedback_divider,
  .i_power_down, .i_idle, .o_boot_valid, .o_boot_mode, .o_debug_refused,
  .o_osc_power_en, .o_pll_power_en, .o_clock_mode, .o_n_factor, .o_p_factor,
  .o_k_factor, .o_cpu_clk_en, .o_clock_output_oe);

// File: verification/bcg_strap_model.sv
// Board straps and oscillator source facing the clock generation block
`timescale 1ns/1ps
module bcg_strap_model (
  input  wire logic       i_clk,
  input  wire logic [2:0] i_strap,
  input  wire logic       i_osc_run,
  input  wire logic       i_osc_power_en,
  input  wire logic       i_pin_val,
  input  wire logic       i_pin_oe,
  output wire logic       o_boot_select_pin,
  output wire logic       o_tms,
  output wire logic       o_port0_bit0,
  output logic            o_osc_clk
);
  logic [3:0] osc_cnt = 4'h0;
  assign o_boot_select_pin = i_strap[2];
  assign o_tms = i_strap[1];
  // Shared pin carries the clock output once the device drives it
  assign o_port0_bit0 = i_pin_oe ? i_pin_val : i_strap[0];
  initial o_osc_clk = 1'b0;
  // Oscillator stands still when stopped or powered down
  always @(posedge i_clk) begin
    if (i_osc_run && i_osc_power_en) begin
      osc_cnt <= (osc_cnt == 4'hb) ? 4'h0 : osc_cnt + 4'h1;
      if (osc_cnt == 4'hb) o_osc_clk <= ~o_osc_clk;
    end
  end
endmodule // bcg_strap_model

// File: verification/tb_bcg_clock_gen.sv
// Self-checking testbench for the boot and clock generation block
`timescale 1ns/1ps
`include "bcg_defs.vh"
module tb_bcg_clock_gen;
  logic       i_clk, i_rst_n, i_flash_protected, i_ext_osc_select, osc_run;
  logic       i_osc_disconnect, i_vco_bypass, i_toggle_latch_enable;
  logic       i_clock_output_pin_enable, i_idle, i_slowdown, i_power_down, i_pll_locked;
  logic [5:0] i_feedback_divider;
  logic [1:0] i_clock_output_pin_select;
  logic [3:0] i_slowdown_factor;
  logic [2:0] strap;
  logic [7:0] row;
  wire        i_boot_select_pin, i_tms, i_port0_bit0, i_osc_clk, o_boot_valid;
  wire        o_debug_refused, o_jtag_active, o_ext_osc_en, o_osc_power_en;
  wire        o_pll_power_en, o_osc_fail, o_lock_lost, o_cpu_clk_en;
  wire        o_clock_output_pin, o_clock_output_oe;
  wire        o_periph_clk_en, o_ccu_clk_en, o_flash_fast_en, o_flash_slow_en;
  wire  [5:0] watch;
  wire [15:0] o_pc_start;
  wire  [1:0] o_boot_mode, o_clock_mode;
  wire  [5:0] o_n_factor;
  wire  [7:0] o_p_factor, o_k_factor;
  int         n_fail, n_tests, k;
  int         cn [6];
  int         cycles = 0;
  // Protect, select, tms, bit0, boot mode, jtag, refused
  logic [7:0] rows [6] = '{8'h40, 8'h14, 8'h2a, 8'ha1, 8'h6e, 8'h70};
  // Strobes watched by the counter, pin in the top bit
  assign watch = {o_clock_output_pin, o_flash_slow_en, o_flash_fast_en,
                  o_ccu_clk_en, o_periph_clk_en, o_cpu_clk_en};
  bcg_clock_gen bcg_clock_gen_i (
    .i_clk, .i_rst_n, .i_boot_select_pin, .i_tms, .i_port0_bit0,
    .i_flash_protected, .i_ext_osc_select, .i_osc_disconnect, .i_vco_bypass,
    .i_feedback_divider, .i_toggle_latch_enable, .i_clock_output_pin_select,
    .i_clock_output_pin_enable, .i_idle, .i_slowdown, .i_slowdown_factor,
    .i_power_down, .i_osc_clk, .i_pll_locked, .o_boot_mode, .o_boot_valid,
    .o_debug_refused, .o_jtag_active, .o_pc_start, .o_ext_osc_en,
    .o_osc_power_en, .o_pll_power_en, .o_clock_mode, .o_n_factor,
    .o_p_factor, .o_k_factor, .o_osc_fail, .o_lock_lost, .o_cpu_clk_en,
    .o_periph_clk_en, .o_ccu_clk_en, .o_flash_fast_en,
    .o_flash_slow_en, .o_clock_output_pin, .o_clock_output_oe);
  bcg_strap_model bcg_strap_model_i (
    .i_clk, .i_strap(strap), .i_osc_run(osc_run),
    .i_osc_power_en(o_osc_power_en), .i_pin_val(o_clock_output_pin),
    .i_pin_oe(o_clock_output_oe), .o_boot_select_pin(i_boot_select_pin),
    .o_tms(i_tms), .o_port0_bit0(i_port0_bit0), .o_osc_clk(i_osc_clk));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  // Counts high cycles of each watched strobe, returns at a rising edge
  task automatic count(input int n);
    cn = '{default: 0};
    repeat (n) begin
      @(negedge i_clk);
      foreach (cn[j]) cn[j] += (watch[j] === 1'b1);
    end
    @(posedge i_clk);
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      end_of_test;
    end
  end
  initial begin
    n_fail = 0;
    n_tests = 0;
    {i_rst_n, i_flash_protected, i_ext_osc_select, i_osc_disconnect,
     i_vco_bypass, i_toggle_latch_enable, i_clock_output_pin_enable, i_idle,
     i_slowdown, i_power_down, i_clock_output_pin_select, i_slowdown_factor} = '0;
    i_feedback_divider = 6'h10;
    i_pll_locked = 1'b1;
    osc_run = 1'b1;
    strap = 3'b100;
    foreach (rows[r]) begin
      @(posedge i_clk);
      row = rows[r];
      strap <= row[6:4];
      i_flash_protected <= row[7];
      i_rst_n <= 1'b0;
      settle(2);
      chk(o_n_factor, `BCG_FEEDBACK_DIVIDER_RESET);
      chk({o_osc_power_en, o_pll_power_en, o_ext_osc_en}, 3'b110);
      @(posedge i_clk);
      i_rst_n <= 1'b1;
      for (k = 0; k < 40 && o_boot_valid !== 1'b1; k++) @(posedge i_clk);
      @(negedge i_clk);
      chk(o_boot_valid, 1'b1);
      chk(o_boot_mode, row[3:2]);
      chk(o_jtag_active, row[1]);
      chk(o_debug_refused, row[0]);
      chk(o_pc_start, `BCG_PC_START);
    end
    @(posedge i_clk);
    strap <= 3'b001;
    settle(20);
    chk(o_boot_mode, `BCG_BOOT_USER);
    for (int m = 0; m < 4; m++) begin
      @(posedge i_clk);
      {i_osc_disconnect, i_vco_bypass} <= m[1:0];
      settle(2);
      chk(o_clock_mode, m[1] ? `BCG_MODE_BASE :
          m[0] ? `BCG_MODE_PRESCALE : `BCG_MODE_PLL);
    end
    @(posedge i_clk);
    {i_osc_disconnect, i_vco_bypass} <= 2'b00;
    i_feedback_divider <= 6'h20;
    i_ext_osc_select <= 1'b1;
    settle(2);
    chk(o_n_factor, 6'h20);
    chk({o_p_factor, o_k_factor}, {`BCG_P_FACTOR, `BCG_K_FACTOR});
    chk(o_ext_osc_en, 1'b1);
    count(120);
    chk(cn[0], 40);
    chk(cn[1], 40);
    chk(cn[2], 40);
    chk(cn[3], 120);
    chk(cn[4], 40);
    i_slowdown <= 1'b1;
    i_slowdown_factor <= 4'h2;
    repeat (12) @(posedge i_clk);
    count(120);
    chk(cn[0] >= 9 && cn[0] <= 11, 1'b1);
    chk(cn[1], 10);
    chk(cn[2], 10);
    i_slowdown <= 1'b0;
    i_idle <= 1'b1;
    repeat (6) @(posedge i_clk);
    count(60);
    chk(cn[0], 0);
    chk(cn[1], 20);
    i_idle <= 1'b0;
    {i_clock_output_pin_select, i_clock_output_pin_enable, i_toggle_latch_enable} <= 4'hf;
    repeat (6) @(posedge i_clk);
    count(60);
    chk(cn[5], 30);
    chk(o_clock_output_oe, 1'b1);
    {i_clock_output_pin_select, i_toggle_latch_enable} <= 3'b100;
    repeat (6) @(posedge i_clk);
    count(60);
    chk(cn[5], 20);
    i_toggle_latch_enable <= 1'b1;
    repeat (6) @(posedge i_clk);
    count(60);
    chk(cn[5], 30);
    i_power_down <= 1'b1;
    settle(2);
    chk({o_osc_power_en, o_pll_power_en}, 2'b00);
    @(posedge i_clk);
    i_power_down <= 1'b0;
    osc_run <= 1'b0;
    settle(130);
    chk(o_osc_fail, 1'b1);
    chk(o_lock_lost, 1'b0);
    @(posedge i_clk);
    osc_run <= 1'b1;
    i_pll_locked <= 1'b0;
    settle(10);
    chk(o_lock_lost, 1'b1);
    end_of_test;
  end
endmodule // tb_bcg_clock_gen
